// ===== design/rtc_i2c_target.sv
// rtc two-wire target port: address match, counter, read and write paths
`timescale 1ns/1ns
module rtc_i2c_target
  import rtc_i2c_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_MAX_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_osc_run,
  output logic [7:0]      o_rd_addr,
  input  wire logic [7:0] i_rd_data,
  output logic            o_wr_valid,
  input  wire logic       i_wr_ready,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data,
  i2c_link_if.target      link
);
  typedef enum logic [2:0] {
    T_IDLE     = 3'b000,
    T_ADDR     = 3'b001,
    T_ADDR_ACK = 3'b011,
    T_WR       = 3'b010,
    T_WR_ACK   = 3'b110,
    T_RD       = 3'b111,
    T_RD_ACK   = 3'b101,
    T_IGNORE   = 3'b100
  } tgt_state_t;

  typedef struct packed {
    logic [1:0]       scl_sync;
    logic [1:0]       sda_sync;
    logic [1:0]       osc_sync;
    logic             scl_last;
    logic             sda_last;
    logic             scl_f;
    logic             sda_f;
    tgt_state_t       st;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic             first;
    logic             rw;
    logic             ack;
    logic             sda_oe;
    logic             push;
    logic [15:0]      push_data;
    logic [TO_W-1:0]  timer;
  } tgt_ff_t;

  tgt_ff_t cur_ff;
  tgt_ff_t nxt_ff;
  logic    scl_rise;
  logic    scl_fall;
  logic    sda_rise;
  logic    sda_fall;
  logic    start_seen;
  logic    stop_seen;
  logic    timed_out;
  logic    fifo_ready;

  // a full fifo makes the target nack the byte, the only stall it has
  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (cur_ff.push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (cur_ff.push_data),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  ({o_wr_addr, o_wr_data})
  );

  // pin outputs straight from flops; clock line is never touched
  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = cur_ff.sda_oe;
  assign o_rd_addr     = cur_ff.ptr;

  always_comb begin
    nxt_ff      = cur_ff;
    nxt_ff.push = 1'b0;
    // two-flop synchroniser, then a level kept only after two equal samples
    nxt_ff.scl_sync = {cur_ff.scl_sync[0], link.scl};
    nxt_ff.sda_sync = {cur_ff.sda_sync[0], link.sda};
    nxt_ff.osc_sync = {cur_ff.osc_sync[0], i_osc_run}; // comes from the timekeeping domain
    nxt_ff.scl_last = cur_ff.scl_sync[1];
    nxt_ff.sda_last = cur_ff.sda_sync[1];
    if (cur_ff.scl_sync[1] == cur_ff.scl_last) begin
      nxt_ff.scl_f = cur_ff.scl_last;
    end
    if (cur_ff.sda_sync[1] == cur_ff.sda_last) begin
      nxt_ff.sda_f = cur_ff.sda_last;
    end
    scl_rise   = nxt_ff.scl_f & ~cur_ff.scl_f;
    scl_fall   = ~nxt_ff.scl_f & cur_ff.scl_f;
    sda_rise   = nxt_ff.sda_f & ~cur_ff.sda_f;
    sda_fall   = ~nxt_ff.sda_f & cur_ff.sda_f;
    start_seen = cur_ff.scl_f & nxt_ff.scl_f & sda_fall;
    stop_seen  = cur_ff.scl_f & nxt_ff.scl_f & sda_rise;

    // low-clock timer runs off the oscillator-enabled qualifier only
    timed_out = (cur_ff.timer == TO_W'(TIMEOUT_CYC - 1));
    if (nxt_ff.scl_f || !cur_ff.osc_sync[1]) begin
      nxt_ff.timer = '0;
    end else if (!timed_out) begin
      nxt_ff.timer = cur_ff.timer + 1'b1;
    end

    if (timed_out) begin
      nxt_ff.st     = T_IDLE;
      nxt_ff.sda_oe = 1'b0;
    end else if (start_seen) begin
      // repeated start keeps the counter, so a dummy write positions reads
      nxt_ff.st     = T_ADDR;
      nxt_ff.bits   = '0;
      nxt_ff.sda_oe = 1'b0;
    end else if (stop_seen) begin
      nxt_ff.st     = T_IDLE;
      nxt_ff.sda_oe = 1'b0;
    end else begin
      unique case (cur_ff.st)
        T_IDLE, T_IGNORE: begin
          nxt_ff.sda_oe = 1'b0;
        end
        T_ADDR: begin
          if (scl_rise) begin
            nxt_ff.sh   = {cur_ff.sh[6:0], nxt_ff.sda_f};
            nxt_ff.bits = cur_ff.bits + 1'b1;
          end else if (scl_fall && cur_ff.bits == BITS_PER_BYTE) begin
            if (cur_ff.sh[7:1] == TARGET_ADDR7) begin
              nxt_ff.rw     = cur_ff.sh[0];
              nxt_ff.sda_oe = 1'b1;
              nxt_ff.st     = T_ADDR_ACK;
            end else begin
              nxt_ff.st = T_IGNORE;
            end
          end
        end
        T_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_ff.bits = '0;
            if (cur_ff.rw) begin
              // first read byte comes from wherever the counter points
              nxt_ff.sh     = i_rd_data;
              nxt_ff.sda_oe = ~i_rd_data[7];
              nxt_ff.ptr    = cur_ff.ptr + 1'b1;
              nxt_ff.st     = T_RD;
            end else begin
              nxt_ff.sda_oe = 1'b0;
              nxt_ff.first  = 1'b1;
              nxt_ff.st     = T_WR;
            end
          end
        end
        T_WR: begin
          if (scl_rise) begin
            nxt_ff.sh   = {cur_ff.sh[6:0], nxt_ff.sda_f};
            nxt_ff.bits = cur_ff.bits + 1'b1;
          end else if (scl_fall && cur_ff.bits == BITS_PER_BYTE) begin
            nxt_ff.st = T_WR_ACK;
            if (cur_ff.first) begin
              nxt_ff.ptr    = cur_ff.sh;
              nxt_ff.first  = 1'b0;
              nxt_ff.sda_oe = 1'b1;
            end else if (fifo_ready) begin
              nxt_ff.push      = 1'b1;
              nxt_ff.push_data = {cur_ff.ptr, cur_ff.sh};
              nxt_ff.ptr       = cur_ff.ptr + 1'b1;
              nxt_ff.sda_oe    = 1'b1;
            end else begin
              nxt_ff.sda_oe = 1'b0; // no room: nack
            end
          end
        end
        T_WR_ACK: begin
          if (scl_fall) begin
            nxt_ff.sda_oe = 1'b0;
            nxt_ff.bits   = '0;
            nxt_ff.st     = T_WR;
          end
        end
        T_RD: begin
          if (scl_rise) begin
            nxt_ff.bits = cur_ff.bits + 1'b1;
          end else if (scl_fall) begin
            if (cur_ff.bits == BITS_PER_BYTE) begin
              nxt_ff.sda_oe = 1'b0; // master owns the ack bit
              nxt_ff.bits   = '0;
              nxt_ff.st     = T_RD_ACK;
            end else begin
              nxt_ff.sh     = {cur_ff.sh[6:0], 1'b0};
              nxt_ff.sda_oe = ~cur_ff.sh[6];
            end
          end
        end
        T_RD_ACK: begin
          if (scl_rise) begin
            nxt_ff.ack = ~nxt_ff.sda_f;
          end else if (scl_fall) begin
            if (cur_ff.ack) begin
              nxt_ff.sh     = i_rd_data;
              nxt_ff.sda_oe = ~i_rd_data[7];
              nxt_ff.ptr    = cur_ff.ptr + 1'b1;
              nxt_ff.st     = T_RD;
            end else begin
              nxt_ff.sda_oe = 1'b0;
              nxt_ff.st     = T_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur_ff          <= '0;
      cur_ff.scl_sync <= 2'h3;
      cur_ff.sda_sync <= 2'h3;
      cur_ff.scl_last <= 1'b1;
      cur_ff.sda_last <= 1'b1;
      cur_ff.scl_f    <= 1'b1;
      cur_ff.sda_f    <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule

// ===== design/rtc_i2c_pkg.sv
// shared constants for the rtc serial target port and its bus master
// How it works
// - read bytes go out MSB first, master acks
// - master nacks last read byte, target releases data
// - first byte after start is address byte
// - answer only to d0h write, d1h read
// - wrong address: stay silent until next start
// - first write byte loads the address counter
// - master single write: start, addr, reg, data, stop
// - further write bytes go to consecutive locations
// - reads start at current address counter
// - master single read: start, d1h, byte, nack, stop; this master always sends start, d0h, reg, then a repeated start first
// - dummy write then repeated start positions reads
// - master acks wanted bytes, target sends next location
// - master never holds the clock low long
// - clock low past timeout resets port, releases data
// - timeout counts only while oscillator runs
// - target never drives or stretches the clock
// - target drives data only low or releases it
// - ninth bit is ack, low acks, high nacks
// - sample on rising clock, change on falling clock
// - start and stop seen while clock is high
package rtc_i2c_pkg;
  localparam logic [6:0]  TARGET_ADDR7          = 7'h68;
  localparam logic [7:0]  ADDR_BYTE_WR          = 8'hd0;
  localparam logic [7:0]  ADDR_BYTE_RD          = 8'hd1;
  localparam logic [3:0]  BITS_PER_BYTE         = 4'h8;
  localparam int unsigned CLK_PERIOD_NS         = 20;
  localparam int unsigned CLK_MHZ               = 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUS_TIMEOUT_MIN_TIME_US = 25000;
  localparam int unsigned BUS_TIMEOUT_MAX_TIME_US = 35000;
  localparam int unsigned TIMEOUT_MAX_CYC       = BUS_TIMEOUT_MAX_TIME_US * CLK_MHZ;
  localparam int unsigned TO_W                  = 21;
  localparam int unsigned SCL_PERIOD_NS         = 2500;
  localparam int unsigned QUARTER_CYC           =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int unsigned DIV_W                 = 6;
  localparam int unsigned FIFO_WIDTH            = 16;
  localparam int unsigned FIFO_DEPTH            = 8;
endpackage

// ===== design/i2c_link_if.sv
// two-wire link between the bus master and the rtc target port
`timescale 1ns/1ns
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups: any enabled low driver pulls the line
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host   (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport target (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// ===== design/byte_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_ff_t;

  fifo_ff_t cur_ff;
  fifo_ff_t nxt_ff;
  logic     push;
  logic     pop;

  // count kept one bit wider so full and empty are exact
  assign o_in_ready  = (cur_ff.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (cur_ff.cnt != '0);
  assign o_out_data  = cur_ff.mem[cur_ff.rd];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // pointers wrap at depth, which need not be a power of two
  always_comb begin
    nxt_ff = cur_ff;
    if (push) begin
      nxt_ff.mem[cur_ff.wr] = i_in_data;
      nxt_ff.wr = (cur_ff.wr == AW'(DEPTH - 1)) ? '0 : cur_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_ff.rd = (cur_ff.rd == AW'(DEPTH - 1)) ? '0 : cur_ff.rd + 1'b1;
    end
    nxt_ff.cnt = cur_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule

// ===== design/i2c_bus_master.sv
// two-wire bus master: register write, or dummy write and multi-byte read
`timescale 1ns/1ns
module i2c_bus_master
  import rtc_i2c_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_cmd_valid,
  output logic            o_cmd_ready,
  input  wire logic       i_cmd_read,
  input  wire logic [7:0] i_cmd_reg,
  input  wire logic [7:0] i_cmd_wdata,
  input  wire logic [3:0] i_cmd_count,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  output logic            o_nack,
  i2c_link_if.host        link
);
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_BYTE  = 2'b11,
    M_STOP  = 2'b10
  } mst_state_t;

  typedef struct packed {
    logic [1:0]       sda_sync;
    mst_state_t       st;
    logic [2:0]       step;
    logic [1:0]       q;
    logic [DIV_W-1:0] div;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic             rx;
    logic             rd;
    logic             ackbit;
    logic [3:0]       left;
    logic [7:0]       reg_a;
    logic [7:0]       wdata;
    logic             scl_low;
    logic             sda_low;
    logic             nack;
    logic             rd_valid;
    logic [7:0]       rd_data;
    logic             ready;
  } mst_ff_t;

  mst_ff_t cur_ff;
  mst_ff_t nxt_ff;
  logic    tick;

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = cur_ff.scl_low;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = cur_ff.sda_low;
  assign o_cmd_ready   = cur_ff.ready;
  assign o_rd_valid    = cur_ff.rd_valid;
  assign o_rd_data     = cur_ff.rd_data;
  assign o_nack        = cur_ff.nack;

  always_comb begin
    nxt_ff          = cur_ff;
    nxt_ff.rd_valid = 1'b0;
    nxt_ff.sda_sync = {cur_ff.sda_sync[0], link.sda};
    tick = (cur_ff.div == DIV_W'(QUARTER_CYC - 1));
    nxt_ff.div = (tick || cur_ff.st == M_IDLE) ? '0 : cur_ff.div + 1'b1;
    if (tick && cur_ff.st != M_IDLE) begin
      nxt_ff.q = cur_ff.q + 1'b1;
    end

    unique case (cur_ff.st)
      M_IDLE: begin
        // clock left released while idle, never held low
        nxt_ff.scl_low = 1'b0;
        nxt_ff.sda_low = 1'b0;
        if (i_cmd_valid && cur_ff.ready) begin
          nxt_ff.ready = 1'b0;
          nxt_ff.nack  = 1'b0;
          nxt_ff.rd    = i_cmd_read;
          nxt_ff.reg_a = i_cmd_reg;
          nxt_ff.wdata = i_cmd_wdata;
          nxt_ff.left  = (i_cmd_count == '0) ? 4'h1 : i_cmd_count;
          nxt_ff.step  = 3'h0;
          nxt_ff.q     = 2'h0;
          nxt_ff.st    = M_START;
        end
      end
      M_START: if (tick) begin
        unique case (cur_ff.q)
          2'h0: begin nxt_ff.scl_low = 1'b1; nxt_ff.sda_low = 1'b0; end
          2'h1: nxt_ff.scl_low = 1'b0;
          2'h2: nxt_ff.sda_low = 1'b1;
          2'h3: begin
            nxt_ff.scl_low = 1'b1;
            nxt_ff.bits    = '0;
            nxt_ff.rx      = 1'b0;
            nxt_ff.sh      = (cur_ff.step == 3'h0) ? ADDR_BYTE_WR : ADDR_BYTE_RD;
            nxt_ff.step    = cur_ff.step + 1'b1;
            nxt_ff.st      = M_BYTE;
          end
        endcase
      end
      M_BYTE: if (tick) begin
        unique case (cur_ff.q)
          2'h0: begin
            // data changes only while the clock is low
            nxt_ff.scl_low = 1'b1;
            if (cur_ff.bits == BITS_PER_BYTE) begin
              nxt_ff.sda_low = cur_ff.rx & (cur_ff.left != 4'h1);
            end else begin
              nxt_ff.sda_low = ~cur_ff.rx & ~cur_ff.sh[7];
            end
          end
          2'h1: nxt_ff.scl_low = 1'b0;
          2'h2: begin
            if (cur_ff.bits == BITS_PER_BYTE) begin
              nxt_ff.ackbit = cur_ff.sda_sync[1];
            end else begin
              nxt_ff.sh = {cur_ff.sh[6:0], cur_ff.rx ? cur_ff.sda_sync[1] : 1'b0};
            end
          end
          2'h3: begin
            nxt_ff.scl_low = 1'b1;
            nxt_ff.bits    = cur_ff.bits + 1'b1;
            if (cur_ff.bits == BITS_PER_BYTE) begin
              nxt_ff.bits = '0;
              if (!cur_ff.rx && cur_ff.ackbit) begin
                nxt_ff.nack = 1'b1; // target refused: give up
                nxt_ff.st   = M_STOP;
              end else begin
                unique case (cur_ff.step)
                  3'h1: begin nxt_ff.sh = cur_ff.reg_a; nxt_ff.step = 3'h2; end
                  3'h2: begin
                    nxt_ff.step = 3'h3;
                    if (cur_ff.rd) begin
                      nxt_ff.sda_low = 1'b0;
                      nxt_ff.st      = M_START;
                    end else begin
                      nxt_ff.sh = cur_ff.wdata;
                    end
                  end
                  3'h4: begin nxt_ff.rx = 1'b1; nxt_ff.step = 3'h5; end
                  3'h5: begin
                    nxt_ff.rd_valid = 1'b1;
                    nxt_ff.rd_data  = cur_ff.sh;
                    nxt_ff.left     = cur_ff.left - 1'b1;
                    if (cur_ff.left == 4'h1) begin
                      nxt_ff.st = M_STOP;
                    end
                  end
                  default: nxt_ff.st = M_STOP;
                endcase
              end
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        unique case (cur_ff.q)
          2'h0: begin nxt_ff.scl_low = 1'b1; nxt_ff.sda_low = 1'b1; end
          2'h1: nxt_ff.scl_low = 1'b0;
          2'h2: nxt_ff.sda_low = 1'b0;
          2'h3: begin nxt_ff.ready = 1'b1; nxt_ff.st = M_IDLE; end
        endcase
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur_ff          <= '0;
      cur_ff.sda_sync <= 2'h3;
      cur_ff.ready    <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule

// ===== tb/rtc_i2c_link_monitor.sv
// link checker: target and master behaviour seen on the shared wires
`timescale 1ns/1ns
module rtc_i2c_link_monitor
  import rtc_i2c_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = 200
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic        scl_ff;
  logic        sda_ff;
  logic        first_ff;
  logic        rd_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  sh_ff;
  logic [15:0] lo_ff;
  logic        rise;
  logic        start;

  // raw edges; no filter needed, both ends are clean logic
  assign rise  = scl & ~scl_ff;
  assign start = scl & scl_ff & sda_ff & ~sda;

  // bit count, shifted byte and direction since the last start
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      first_ff <= 1'b0;
      rd_ff    <= 1'b0;
      cnt_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      lo_ff    <= 16'h0000;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      lo_ff  <= scl ? 16'h0000 : lo_ff + 16'h0001;
      if (start) begin
        cnt_ff   <= 4'h0;
        first_ff <= 1'b1;
        rd_ff    <= 1'b0;
      end else if (rise) begin
        sh_ff  <= {sh_ff[6:0], sda};
        cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
        if (cnt_ff == 4'h8) begin
          first_ff <= 1'b0;
          rd_ff    <= first_ff ? sh_ff[0] : rd_ff;
        end
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // ninth rise of the byte after a start, and a nack ending a read
  sequence addr_end_s;
    rise && cnt_ff == 4'h8 && first_ff;
  endsequence
  sequence rd_nack_s;
    rise && cnt_ff == 4'h8 && !first_ff && rd_ff && sda;
  endsequence
  sequence released_s;
    !d_sda_oe [*8];
  endsequence

  low_only_a: assert property (d_sda_oe |-> !d_sda_o)
    else $error("target drove data high");
  host_low_a: assert property (!(m_scl_oe && m_scl_o) && !(m_sda_oe && m_sda_o))
    else $error("master drove a line high");
  change_low_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("target changed data while clock high");
  addr_ack_a:
    assert property (addr_end_s ##0 (sh_ff == ADDR_BYTE_WR || sh_ff == ADDR_BYTE_RD)
      |-> d_sda_oe && !sda) else $error("own address not acknowledged");
  addr_byte_a: assert property (addr_end_s |-> sh_ff[7:1] == TARGET_ADDR7)
    else $error("master sent a foreign address");
  rd_bits_a:
    assert property (rise && rd_ff && !first_ff && cnt_ff != 4'h0 && cnt_ff != 4'h8
      |-> !(m_sda_oe && !m_sda_o)) else $error("master drove data in a read byte");
  ack_slot_a:
    assert property (rise && rd_ff && !first_ff && cnt_ff == 4'h8 |-> !d_sda_oe)
      else $error("target held data in the ack slot");
  nack_rel_a: assert property (rd_nack_s |-> released_s)
    else $error("target kept data after nack");
  low_bound_a: assert property (lo_ff < 16'(TIMEOUT_CYC))
    else $error("master held clock low too long");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high pulse cut short");
endmodule

// ===== tb/rtc_i2c_slave_port_bench.sv
// bench: master against target, plus a bench-driven second link
`timescale 1ns/1ns
module rtc_i2c_slave_port_bench;
  import rtc_i2c_pkg::*;
  localparam int unsigned TO    = 200;
  localparam int unsigned LIMIT = 95000;
  logic        i_clk_sys = 1'b0;
  logic        i_rst     = 1'b1;
  logic        osc_run   = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_read  = 1'b0;
  logic [7:0]  cmd_reg   = 8'h00;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [3:0]  cmd_count = 4'h0;
  logic        wr_ready  = 1'b1;
  logic        cmd_ready;
  logic        rd_valid;
  logic        nack;
  logic        wr_valid;
  logic [7:0]  rd_data;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_addr2;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  mem [256];
  logic [15:0] exp_q [$];
  logic [7:0]  rdq [$];
  logic [16:0] rnd = 17'h1_3364;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  i2c_link_if link ();
  i2c_link_if link2 ();
  i2c_bus_master u_i2c_bus_master (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read),
    .i_cmd_reg(cmd_reg), .i_cmd_wdata(cmd_wdata), .i_cmd_count(cmd_count),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_nack(nack), .link(link));
  rtc_i2c_target #(.TIMEOUT_CYC(TO)) u_rtc_i2c_target (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_osc_run(osc_run), .o_rd_addr(rd_addr), .i_rd_data(mem[rd_addr]),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .link(link));
  // second target faces the bench, which breaks the master's rules on purpose
  rtc_i2c_target #(.TIMEOUT_CYC(TO)) u_rtc_i2c_target_2 (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_osc_run(osc_run), .o_rd_addr(rd_addr2), .i_rd_data(8'h00),
    .o_wr_valid(), .i_wr_ready(1'b1), .o_wr_addr(), .o_wr_data(), .link(link2));
  rtc_i2c_link_monitor #(.TIMEOUT_CYC(TO)) u_rtc_i2c_link_monitor (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .m_scl_o(link.m_scl_o),
    .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));

  always #10 i_clk_sys = ~i_clk_sys;

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // a count of zero still reads one byte
  function automatic logic [7:0] bytes_of(input logic [3:0] n);
    return (n == 4'h0) ? 8'h01 : {4'h0, n};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // a hang counts as a mismatch
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  // register map side: drain the fifo into the model, collect read bytes
  always @(posedge i_clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk("fifo head", exp_q.pop_front(), {wr_addr, wr_data});
      mem[wr_addr] = wr_data;
    end
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);
  end

  // request held one edge while ready is high, then wait for idle again
  task automatic cmd(input logic r, input logic [7:0] rg, wd, input logic [3:0] n);
    @(posedge i_clk_sys);
    cmd_valid <= 1'b1;
    cmd_read  <= r;
    cmd_reg   <= rg;
    cmd_wdata <= wd;
    cmd_count <= n;
    @(posedge i_clk_sys);
    cmd_valid <= 1'b0;
    tick(3);
    while (cmd_ready !== 1'b1)
      @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [7:0] rg, wd, input logic ok);
    if (ok)
      exp_q.push_back({rg, wd});
    cmd(1'b0, rg, wd, 4'h0);
    chk("write nack", {15'h0, ~ok}, {15'h0, nack});
    chk("counter after write", 8'(ok ? rg + 8'h01 : rg), rd_addr);
  endtask
  task automatic rd(input logic [7:0] rg, input logic [3:0] n);
    rdq.delete();
    cmd(1'b1, rg, 8'h00, n);
    chk("read count", bytes_of(n), 16'(rdq.size()));
    foreach (rdq[i])
      chk("read byte", mem[rg + 8'(i)], rdq[i]);
    chk("counter after read", 8'(rg + bytes_of(n)), rd_addr);
  endtask

  // second link: bench plays master at a 160 ns bit time
  task automatic bit2(input logic b);
    link2.m_sda_oe <= ~b;
    tick(2);
    link2.m_scl_oe <= 1'b0;
    tick(4);
    link2.m_scl_oe <= 1'b1;
    tick(2);
  endtask
  task automatic byte2(input logic [7:0] b, input logic st);
    if (st) begin
      link2.m_sda_oe <= 1'b1;
      tick(4);
      link2.m_scl_oe <= 1'b1;
      tick(4);
    end
    for (int i = 7; i >= 0; i--)
      bit2(b[i]);
    link2.m_sda_oe <= 1'b0;
    tick(16);
  endtask
  task automatic stop2;
    bit2(1'b1);
    link2.m_sda_oe <= 1'b1;
    tick(2);
    link2.m_scl_oe <= 1'b0;
    tick(4);
    link2.m_sda_oe <= 1'b0;
    tick(4);
  endtask

  initial begin
    link2.m_scl_o  = 1'b0;
    link2.m_sda_o  = 1'b0;
    link2.m_scl_oe = 1'b0;
    link2.m_sda_oe = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    tick(10);
    i_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr({1'b0, rnd[6:0]}, rnd[16:9], 1'b1);
    end
    // stalled fifo: eight bytes fit, the ninth is refused
    wr_ready <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      wr(8'h40 + 8'(i), rnd[7:0], i < 8);
    end
    wr_ready <= 1'b1;
    tick(12);
    chk("fifo drained", 16'h0000, 16'(exp_q.size()));
    $display("test writes done");
    rd(8'h40, 4'h8);
    rd(8'h10, 4'h0);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      rd({1'b0, rnd[6:0]}, {2'b00, rnd[9:8]} + 4'h1);
    end
    $display("test reads done");
    // ack must survive a stopped oscillator, then time out once it runs
    osc_run <= 1'b0;
    byte2(ADDR_BYTE_WR, 1'b1);
    tick(TO);
    chk("ack held", 16'h0001, {15'h0, link2.d_sda_oe});
    osc_run <= 1'b1;
    tick(TO + 20);
    chk("timeout release", 16'h0000, {15'h0, link2.d_sda_oe});
    link2.m_scl_oe <= 1'b0;
    tick(8);
    byte2(ADDR_BYTE_WR, 1'b1);
    chk("ack after timeout", 16'h0001, {15'h0, link2.d_sda_oe});
    // one transfer: register byte, then two data bytes; msb kept low so the
    // target's ack release never meets a rising data bit
    bit2(1'b1);
    byte2(8'h20, 1'b0);
    bit2(1'b1);
    byte2(8'h25, 1'b0);
    bit2(1'b1);
    byte2(8'h5a, 1'b0);
    chk("multi write ack", 16'h0001, {15'h0, link2.d_sda_oe});
    chk("multi write counter", 16'h0022, {8'h00, rd_addr2});
    stop2();
    // foreign address, then our address without a start: both ignored
    byte2(8'hd2, 1'b1);
    chk("foreign address", 16'h0000, {15'h0, link2.d_sda_oe});
    bit2(1'b1);
    byte2(ADDR_BYTE_WR, 1'b0);
    chk("no start", 16'h0000, {15'h0, link2.d_sda_oe});
    stop2();
    $display("test second link done");
    end_of_test();
  end
endmodule
